// ### hdl/ucrd_device.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ucrd_map.svh"
module ucrd_device
  import ucrd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  ucrd_link_if.dev LINK,
  input wire logic SELF_POWERED,
  input wire logic NORMAL_STATE,
  output logic REG_WR,
  output logic REG_RD,
  output logic [11:0] REG_ADDR,
  output logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  output logic [6:0] DEV_ADDR,
  output logic CONFIGURED,
  output logic REMOTE_WAKEUP,
  output logic TEST_MODE,
  output logic [2:0] EP_HALT
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] selfp_q;
  logic [1:0] normal_q;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      selfp_q <= 2'h0;
      normal_q <= 2'h0;
    end else begin
      selfp_q <= {selfp_q[0], SELF_POWERED};
      normal_q <= {normal_q[0], NORMAL_STATE};
    end
  end

  // ----------------------------------------
  // Setup decode
  // ----------------------------------------
  ucrd_cmd_t cmd;
  logic [2:0] ep_sel;
  logic zero_vi;
  logic mac_hit;
  always_comb begin
    ep_sel = 3'h0;
    if (LINK.setup_index == `UCRD_IDX_EP1) begin
      ep_sel = 3'h1;
    end
    if (LINK.setup_index == `UCRD_IDX_EP2) begin
      ep_sel = 3'h2;
    end
    if (LINK.setup_index == `UCRD_IDX_EP3) begin
      ep_sel = 3'h4;
    end
  end
  assign zero_vi = (LINK.setup_value == 16'h0000) && (LINK.setup_index == 16'h0000);
  assign mac_hit = LINK.setup_index[11:0] >= `UCRD_MAC_BASE;

  always_comb begin
    cmd = CMD_BAD;
    case (LINK.setup_req)
      `UCRD_RQ_GET_STATUS: begin
        if (LINK.setup_type == `UCRD_RT_DEV_IN && zero_vi && LINK.setup_length == `UCRD_LEN_STATUS) begin
          cmd = CMD_GET_DEV;
        end
        if (LINK.setup_type == `UCRD_RT_EP_IN && LINK.setup_value == 16'h0000 && ep_sel != 3'h0 &&
            LINK.setup_length == `UCRD_LEN_STATUS) begin
          cmd = CMD_GET_EP;
        end
      end
      `UCRD_RQ_SET_ADDRESS: begin
        if (LINK.setup_type == `UCRD_RT_DEV_OUT && LINK.setup_index == 16'h0000 &&
            LINK.setup_length == 16'h0000 && LINK.setup_value <= `UCRD_ADDR_MAX) begin
          cmd = CMD_SET_ADDR;
        end
      end
      `UCRD_RQ_SET_FEATURE: begin
        if (LINK.setup_length == 16'h0000) begin
          if (LINK.setup_type == `UCRD_RT_DEV_OUT && LINK.setup_index == 16'h0000 &&
              (LINK.setup_value == `UCRD_FEAT_WAKEUP || LINK.setup_value == `UCRD_FEAT_TEST)) begin
            cmd = CMD_FEAT_DEV;
          end
          if (LINK.setup_type == `UCRD_RT_EP_OUT && LINK.setup_value == `UCRD_FEAT_HALT && ep_sel != 3'h0) begin
            cmd = CMD_FEAT_EP;
          end
        end
      end
      `UCRD_RQ_SET_CONFIG: begin
        if (LINK.setup_type == `UCRD_RT_DEV_OUT && LINK.setup_index == 16'h0000 &&
            LINK.setup_length == 16'h0000 && LINK.setup_value == `UCRD_CONFIG_VAL) begin
          cmd = CMD_SET_CFG;
        end
      end
      `UCRD_RQ_SET_IFACE: begin
        if (LINK.setup_type == `UCRD_RT_IF_OUT && zero_vi && LINK.setup_length == 16'h0000) begin
          cmd = CMD_SET_IF;
        end
      end
      `UCRD_RQ_REG_WRITE: begin
        if (LINK.setup_type == `UCRD_RT_VND_OUT && LINK.setup_value == 16'h0000 &&
            LINK.setup_index[15:12] == 4'h0 && LINK.setup_length == `UCRD_LEN_REG) begin
          cmd = CMD_REG_WR;
        end
      end
      `UCRD_RQ_REG_READ: begin
        if (LINK.setup_type == `UCRD_RT_VND_IN && LINK.setup_value == 16'h0000 &&
            LINK.setup_index[15:12] == 4'h0 && LINK.setup_length == `UCRD_LEN_REG) begin
          cmd = CMD_REG_RD;
        end
      end
      default: begin
        cmd = CMD_BAD;
      end
    endcase
    // MAC space closed while in Normal power state
    if ((cmd == CMD_REG_WR || cmd == CMD_REG_RD) && mac_hit && normal_q[1]) begin
      cmd = CMD_BAD;
    end
  end

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  ucrd_dev_state_t state_q;
  logic rsp_valid_q;
  logic rsp_stall_q;
  logic [31:0] rsp_data_q;
  logic reg_wr_q;
  logic reg_rd_q;
  logic [11:0] reg_addr_q;
  logic [31:0] reg_wdata_q;
  logic take;
  assign take = (state_q == DS_IDLE) && LINK.setup_valid;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_q <= DS_IDLE;
      rsp_valid_q <= 1'b0;
      rsp_stall_q <= 1'b0;
      rsp_data_q <= 32'h0000_0000;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= 12'h000;
      reg_wdata_q <= 32'h0000_0000;
    end else begin
      rsp_valid_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      case (state_q)
        DS_IDLE: begin
          if (take) begin
            rsp_data_q <= 32'h0000_0000;
            rsp_stall_q <= 1'b0;
            reg_addr_q <= LINK.setup_index[11:0];
            case (cmd)
              CMD_REG_WR: begin
                state_q <= DS_WDATA;
              end
              CMD_REG_RD: begin
                reg_rd_q <= 1'b1;
                state_q <= DS_RD1;
              end
              CMD_GET_DEV: begin
                rsp_valid_q <= 1'b1;
                rsp_data_q <= {30'h0000_0000, REMOTE_WAKEUP, selfp_q[1]};
              end
              CMD_GET_EP: begin
                rsp_valid_q <= 1'b1;
                rsp_data_q <= {31'h0000_0000, |(ep_sel & EP_HALT)};
              end
              CMD_BAD: begin
                rsp_valid_q <= 1'b1;
                rsp_stall_q <= 1'b1;
              end
              default: begin
                rsp_valid_q <= 1'b1;
              end
            endcase
          end
        end
        DS_WDATA: begin
          // Only the first data word is used; no burst
          if (LINK.out_valid) begin
            reg_wr_q <= 1'b1;
            reg_wdata_q <= LINK.out_data;
            rsp_valid_q <= 1'b1;
            state_q <= DS_IDLE;
          end
        end
        DS_RD1: begin
          state_q <= DS_RD2;
        end
        DS_RD2: begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= REG_RDATA;
          state_q <= DS_IDLE;
        end
        default: begin
          state_q <= DS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Device state set by standard requests
  // ----------------------------------------
  logic [6:0] addr_q;
  logic [6:0] addr_pend_q;
  logic pend_q;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      addr_q <= 7'h00;
      addr_pend_q <= 7'h00;
      pend_q <= 1'b0;
    end else begin
      // Held back so the status stage still answers at the old address
      if (take) begin
        pend_q <= (cmd == CMD_SET_ADDR);
        addr_pend_q <= LINK.setup_value[6:0];
      end else if (pend_q && LINK.status_ok) begin
        addr_q <= addr_pend_q;
        pend_q <= 1'b0;
      end
    end
  end

  logic cfg_q;
  logic wake_q;
  logic test_q;
  logic [2:0] halt_q;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= 1'b0;
      wake_q <= 1'b0;
      test_q <= 1'b0;
      halt_q <= 3'h0;
    end else if (take) begin
      if (cmd == CMD_SET_CFG) begin
        cfg_q <= 1'b1;
      end
      if (cmd == CMD_FEAT_DEV && LINK.setup_value == `UCRD_FEAT_WAKEUP) begin
        wake_q <= 1'b1;
      end
      if (cmd == CMD_FEAT_DEV && LINK.setup_value == `UCRD_FEAT_TEST) begin
        test_q <= 1'b1;
      end
      if (cmd == CMD_FEAT_EP) begin
        halt_q <= halt_q | ep_sel;
      end
    end
  end

  assign LINK.rsp_valid = rsp_valid_q;
  assign LINK.rsp_stall = rsp_stall_q;
  assign LINK.rsp_data = rsp_data_q;
  assign REG_WR = reg_wr_q;
  assign REG_RD = reg_rd_q;
  assign REG_ADDR = reg_addr_q;
  assign REG_WDATA = reg_wdata_q;
  assign DEV_ADDR = addr_q;
  assign CONFIGURED = cfg_q;
  assign REMOTE_WAKEUP = wake_q;
  assign TEST_MODE = test_q;
  assign EP_HALT = halt_q;
endmodule

// ### hdl/ucrd_host.sv
`timescale 1ns/1ps
`include "ucrd_map.svh"
module ucrd_host
  import ucrd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [7:0] SW_ADDR,
  input wire logic [31:0] SW_WDATA,
  input wire logic SW_WR,
  input wire logic SW_RD,
  output logic [31:0] SW_RDATA,
  ucrd_link_if.host LINK
);
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [31:0] setup0_q;
  logic [31:0] setup1_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [31:0] sw_rdata_q;
  logic stall_q;
  logic done_q;
  ucrd_host_state_t state_q;
  logic go;
  logic finish;
  assign go = SW_WR && SW_ADDR == `UCRD_H_GO && state_q == HS_IDLE;
  assign finish = LINK.rsp_valid && state_q != HS_IDLE;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      setup0_q <= 32'h0000_0000;
      setup1_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
    end else if (SW_WR) begin
      if (SW_ADDR == `UCRD_H_SETUP0) begin
        setup0_q <= SW_WDATA;
      end
      if (SW_ADDR == `UCRD_H_SETUP1) begin
        setup1_q <= SW_WDATA;
      end
      if (SW_ADDR == `UCRD_H_WDATA) begin
        wdata_q <= SW_WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sw_rdata_q <= 32'h0000_0000;
    end else begin
      sw_rdata_q <= 32'h0000_0000;
      if (SW_RD) begin
        case (SW_ADDR)
          `UCRD_H_SETUP0: sw_rdata_q <= setup0_q;
          `UCRD_H_SETUP1: sw_rdata_q <= setup1_q;
          `UCRD_H_WDATA: sw_rdata_q <= wdata_q;
          `UCRD_H_STATUS: sw_rdata_q <= {29'h0000_0000, done_q, stall_q, state_q != HS_IDLE};
          `UCRD_H_RDATA: sw_rdata_q <= rdata_q;
          default: sw_rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control transfer sequencer
  // ----------------------------------------
  logic setup_valid_q;
  logic out_valid_q;
  logic status_ok_q;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_q <= HS_IDLE;
      setup_valid_q <= 1'b0;
      out_valid_q <= 1'b0;
      status_ok_q <= 1'b0;
      stall_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      setup_valid_q <= 1'b0;
      out_valid_q <= 1'b0;
      status_ok_q <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (go) begin
            setup_valid_q <= 1'b1;
            done_q <= 1'b0;
            stall_q <= 1'b0;
            // OUT data stage only for host-to-device with data
            if (!setup0_q[7] && setup1_q[31:16] != 16'h0000) begin
              state_q <= HS_DATA;
            end else begin
              state_q <= HS_WAIT;
            end
          end
        end
        HS_DATA: begin
          // An answer seen before the data goes out cancels it and ends the transfer; a stall here answers in the same cycle the data goes out
          if (!finish) begin
            out_valid_q <= 1'b1;
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
      if (finish) begin
        state_q <= HS_IDLE;
        stall_q <= LINK.rsp_stall;
        done_q <= 1'b1;
        rdata_q <= LINK.rsp_data;
        status_ok_q <= !LINK.rsp_stall;
      end
    end
  end

  assign LINK.setup_valid = setup_valid_q;
  assign LINK.setup_type = setup0_q[7:0];
  assign LINK.setup_req = setup0_q[15:8];
  assign LINK.setup_value = setup0_q[31:16];
  assign LINK.setup_index = setup1_q[15:0];
  assign LINK.setup_length = setup1_q[31:16];
  assign LINK.out_valid = out_valid_q;
  assign LINK.out_data = wdata_q;
  assign LINK.status_ok = status_ok_q;
  assign SW_RDATA = sw_rdata_q;
endmodule

// ### hdl/ucrd_link_if.sv
`timescale 1ns/1ps
interface ucrd_link_if;
  logic setup_valid;
  logic [7:0] setup_type;
  logic [7:0] setup_req;
  logic [15:0] setup_value;
  logic [15:0] setup_index;
  logic [15:0] setup_length;
  logic out_valid;
  logic [31:0] out_data;
  logic rsp_valid;
  logic rsp_stall;
  logic [31:0] rsp_data;
  logic status_ok;
  modport dev (input setup_valid, setup_type, setup_req, setup_value, setup_index, setup_length,
    out_valid, out_data, status_ok, output rsp_valid, rsp_stall, rsp_data);
  modport host (output setup_valid, setup_type, setup_req, setup_value, setup_index, setup_length,
    out_valid, out_data, status_ok, input rsp_valid, rsp_stall, rsp_data);
endinterface

// ### hdl/ucrd_map.svh
`ifndef UCRD_MAP_SVH
`define UCRD_MAP_SVH

// ----------------------------------------
// Request types and codes
// ----------------------------------------
`define UCRD_RT_DEV_IN 8'h80
`define UCRD_RT_EP_IN 8'h82
`define UCRD_RT_DEV_OUT 8'h00
`define UCRD_RT_IF_OUT 8'h01
`define UCRD_RT_EP_OUT 8'h02
`define UCRD_RT_VND_OUT 8'h40
`define UCRD_RT_VND_IN 8'hC0
`define UCRD_RQ_GET_STATUS 8'h00
`define UCRD_RQ_SET_FEATURE 8'h03
`define UCRD_RQ_SET_ADDRESS 8'h05
`define UCRD_RQ_SET_CONFIG 8'h09
`define UCRD_RQ_SET_IFACE 8'h0B
`define UCRD_RQ_REG_WRITE 8'hA0
`define UCRD_RQ_REG_READ 8'hA1

// ----------------------------------------
// Field values
// ----------------------------------------
`define UCRD_FEAT_HALT 16'h0000
`define UCRD_FEAT_WAKEUP 16'h0001
`define UCRD_FEAT_TEST 16'h0002
`define UCRD_IDX_EP1 16'h0081
`define UCRD_IDX_EP2 16'h0002
`define UCRD_IDX_EP3 16'h0083
`define UCRD_LEN_STATUS 16'h0002
`define UCRD_LEN_REG 16'h0004
`define UCRD_CONFIG_VAL 16'h0001
`define UCRD_ADDR_MAX 16'h007F
`define UCRD_MAC_BASE 12'h100

// ----------------------------------------
// Host software register offsets and status bit positions
// ----------------------------------------
`define UCRD_H_SETUP0 8'h00
`define UCRD_H_SETUP1 8'h04
`define UCRD_H_WDATA 8'h08
`define UCRD_H_GO 8'h0C
`define UCRD_H_STATUS 8'h10
`define UCRD_H_RDATA 8'h14
`define UCRD_ST_BUSY 0
`define UCRD_ST_STALL 1
`define UCRD_ST_DONE 2
`endif

// ### hdl/ucrd_pkg.sv
package ucrd_pkg;
  typedef enum logic [3:0] {
    CMD_GET_DEV, CMD_GET_EP, CMD_SET_ADDR, CMD_FEAT_DEV, CMD_FEAT_EP,
    CMD_SET_CFG, CMD_SET_IF, CMD_REG_WR, CMD_REG_RD, CMD_BAD
  } ucrd_cmd_t;
  typedef enum logic [1:0] {DS_IDLE, DS_WDATA, DS_RD1, DS_RD2} ucrd_dev_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_DATA, HS_WAIT} ucrd_host_state_t;
endpackage

// ### testbench/ucrd_link_assertions.sv
`timescale 1ns/1ps
module ucrd_link_assertions (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic setup_valid,
  input wire logic [7:0] setup_type,
  input wire logic [7:0] setup_req,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  input wire logic rsp_valid,
  input wire logic rsp_stall,
  input wire logic [31:0] rsp_data,
  input wire logic status_ok
);
  // ----------------------------------------
  // Request classes
  // ----------------------------------------
  logic is_vnd, dev_q, ep_q, rd_sys, cfg_bad, if_req, unsup;
  assign is_vnd = setup_type == 8'h40 || setup_type == 8'hC0;
  assign dev_q = setup_type == 8'h80 && setup_req == 8'h00 && setup_value == 16'h0000
    && setup_index == 16'h0000 && setup_length == 16'h0002;
  assign ep_q = setup_type == 8'h82 && setup_req == 8'h00 && setup_value == 16'h0000 && setup_length == 16'h0002
    && (setup_index == 16'h0081 || setup_index == 16'h0002 || setup_index == 16'h0083);
  // Index below the MAC base also pins the upper nibble to zero
  assign rd_sys = setup_type == 8'hC0 && setup_req == 8'hA1 && setup_value == 16'h0000
    && setup_length == 16'h0004 && setup_index < 16'h0100;
  assign cfg_bad = setup_type == 8'h00 && setup_req == 8'h09 && setup_value != 16'h0001;
  assign if_req = setup_type == 8'h01 && setup_req == 8'h0B && setup_length == 16'h0000;
  assign unsup = setup_req == 8'h07 || setup_req == 8'h0C;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_dev_status: assert property (setup_valid && dev_q |=> rsp_valid && !rsp_stall && rsp_data[31:2] == 30'h0)
    else $error("device status word wrong");
  a_ep_status: assert property (setup_valid && ep_q |=> rsp_valid && !rsp_stall && rsp_data[31:1] == 31'h0)
    else $error("endpoint status word wrong");
  a_cfg_stall: assert property (setup_valid && cfg_bad |=> rsp_valid && rsp_stall)
    else $error("bad configuration not stalled");
  a_iface_ack: assert property (setup_valid && if_req && setup_value == 16'h0000 && setup_index == 16'h0000
    |=> rsp_valid && !rsp_stall)
    else $error("interface selection not acknowledged");
  a_iface_stall: assert property (setup_valid && if_req && (setup_value | setup_index) != 16'h0000
    |=> rsp_valid && rsp_stall)
    else $error("interface selection not stalled");
  a_unsup_stall: assert property (setup_valid && unsup |=> rsp_valid && rsp_stall)
    else $error("unsupported request not stalled");
  a_any_answer: assert property (setup_valid && !is_vnd |=> rsp_valid)
    else $error("standard request not answered");
  a_read_latency: assert property (setup_valid && rd_sys |=> !rsp_valid ##1 !rsp_valid ##1 rsp_valid && !rsp_stall)
    else $error("register read answer late or stalled");
  a_write_answer: assert property (out_valid && !rsp_valid |=> rsp_valid)
    else $error("register write not answered");
  a_status_stage: assert property (rsp_valid |=> status_ok == !rsp_stall)
    else $error("status stage wrong");
  c_read: cover property (setup_valid && rd_sys);
  c_stall: cover property (rsp_valid && rsp_stall);
  c_write: cover property (out_valid && !rsp_valid);
endmodule

// ### testbench/usb_ctrl_request_decoder_tb.sv
`timescale 1ns/1ps
`include "ucrd_map.svh"
module usb_ctrl_request_decoder_tb;
  localparam logic [15:0] Z = 16'h0000;
  logic clock, rst_n, self_pwr, normal, sw_wr, sw_rd, reg_wr, reg_rd, configured, wakeup, test_mode;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, reg_wdata, wr_data, st_g, rd_g;
  logic [31:0] reg_rdata = 32'h0;
  logic [11:0] reg_addr, wr_addr;
  logic [6:0] dev_addr;
  logic [2:0] ep_halt;
  int num_errors = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  ucrd_link_if link();
  ucrd_device u_ucrd_device (.CLOCK(clock), .NRST(rst_n), .LINK(link), .SELF_POWERED(self_pwr),
    .NORMAL_STATE(normal), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .DEV_ADDR(dev_addr), .CONFIGURED(configured), .REMOTE_WAKEUP(wakeup),
    .TEST_MODE(test_mode), .EP_HALT(ep_halt));
  ucrd_host u_ucrd_host (.CLOCK(clock), .NRST(rst_n), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr),
    .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .LINK(link));
  ucrd_link_assertions u_ucrd_link_assertions (.CLOCK(clock), .NRST(rst_n), .setup_valid(link.setup_valid),
    .setup_type(link.setup_type), .setup_req(link.setup_req), .setup_value(link.setup_value),
    .setup_index(link.setup_index), .setup_length(link.setup_length), .out_valid(link.out_valid),
    .out_data(link.out_data), .rsp_valid(link.rsp_valid), .rsp_stall(link.rsp_stall),
    .rsp_data(link.rsp_data), .status_ok(link.status_ok));
  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  // Data only in the cycle after a strobe; scrambled otherwise so stale reads show
  always @(posedge clock) begin
    reg_rdata <= reg_rd ? {20'hA_5C30, reg_addr} : ~reg_rdata;
    if (reg_wr) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
  end
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sw_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    @(negedge clock);
    d = sw_rdata;
  endtask
  // One control transfer; data judged only for accepted IN requests
  task automatic xf(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v, input logic [15:0] i,
      input logic [15:0] l, input logic [31:0] w, input logic es, input logic [31:0] ed);
    int n;
    sw_w(`UCRD_H_SETUP0, {v, r, t});
    sw_w(`UCRD_H_SETUP1, {l, i});
    sw_w(`UCRD_H_WDATA, w);
    sw_w(`UCRD_H_GO, 32'h1);
    for (n = 0; n < 20; n++) begin
      sw_r(`UCRD_H_STATUS, st_g);
      if (st_g[`UCRD_ST_BUSY] === 1'b0) break;
    end
    if (n == 20) begin
      num_errors++;
      final_report();
    end
    sw_r(`UCRD_H_RDATA, rd_g);
    chk({30'h0, st_g[`UCRD_ST_DONE], st_g[`UCRD_ST_STALL]}, {30'h0, 1'b1, es});
    if (!es && t[7]) chk(rd_g, ed);
  endtask
  task automatic t_std();
    logic [15:0] idx[3] = '{`UCRD_IDX_EP1, `UCRD_IDX_EP2, `UCRD_IDX_EP3};
    xf(8'h80, 8'h00, Z, Z, 16'h0002, 32'h0, 1'b0, 32'h1);
    for (int k = 0; k < 3; k++) begin
      xf(8'h82, 8'h00, Z, idx[k], 16'h0002, 32'h0, 1'b0, 32'h0);
      xf(8'h02, 8'h03, Z, idx[k], Z, 32'h0, 1'b0, 32'h0);
      xf(8'h82, 8'h00, Z, idx[k], 16'h0002, 32'h0, 1'b0, 32'h1);
      chk({29'h0, ep_halt}, (32'h2 << k) - 32'h1);
    end
    xf(8'h02, 8'h03, Z, 16'h0004, Z, 32'h0, 1'b1, 32'h0);
    xf(8'h00, 8'h03, 16'h0001, Z, Z, 32'h0, 1'b0, 32'h0);
    xf(8'h00, 8'h03, 16'h0002, Z, Z, 32'h0, 1'b0, 32'h0);
    chk({30'h0, test_mode, wakeup}, 32'h3);
    xf(8'h80, 8'h00, Z, Z, 16'h0002, 32'h0, 1'b0, 32'h3);
    // Bus-powered now; the synchroniser needs two edges
    @(posedge clock);
    self_pwr <= 1'b0;
    repeat (3) @(posedge clock);
    xf(8'h80, 8'h00, Z, Z, 16'h0002, 32'h0, 1'b0, 32'h2);
    xf(8'h80, 8'h00, Z, Z, 16'h0004, 32'h0, 1'b1, 32'h0);
    xf(8'h00, 8'h07, 16'h0100, Z, Z, 32'h0, 1'b1, 32'h0);
    xf(8'h82, 8'h0C, Z, 16'h0081, 16'h0002, 32'h0, 1'b1, 32'h0);
  endtask
  task automatic t_cfg();
    xf(8'h00, 8'h09, 16'h0002, Z, Z, 32'h0, 1'b1, 32'h0);
    chk({31'h0, configured}, 32'h0);
    xf(8'h00, 8'h09, 16'h0001, Z, Z, 32'h0, 1'b0, 32'h0);
    chk({31'h0, configured}, 32'h1);
    xf(8'h01, 8'h0B, Z, Z, Z, 32'h0, 1'b0, 32'h0);
    xf(8'h01, 8'h0B, 16'h0001, Z, Z, 32'h0, 1'b1, 32'h0);
    xf(8'h01, 8'h0B, Z, 16'h0001, Z, 32'h0, 1'b1, 32'h0);
    xf(8'h00, 8'h05, 16'h002A, Z, Z, 32'h0, 1'b0, 32'h0);
    chk({25'h0, dev_addr}, 32'h2A);
    xf(8'h00, 8'h05, 16'h0080, Z, Z, 32'h0, 1'b1, 32'h0);
    chk({25'h0, dev_addr}, 32'h2A);
  endtask
  task automatic t_vnd();
    int c;
    c = wr_cnt;
    xf(8'h40, 8'hA0, Z, 16'h00A4, 16'h0004, 32'h1234_5678, 1'b0, 32'h0);
    chk(32'(wr_cnt - c), 32'h1);
    chk({wr_addr, wr_data[19:0]}, 32'hA44_5678);
    xf(8'h40, 8'hA0, Z, 16'h0100, 16'h0004, 32'h0, 1'b0, 32'h0);
    chk({20'h0, wr_addr}, 32'h100);
    xf(8'hC0, 8'hA1, Z, 16'h0FFC, 16'h0004, 32'h0, 1'b0, 32'hA5C3_0FFC);
    xf(8'hC0, 8'hA1, Z, 16'h10B8, 16'h0004, 32'h0, 1'b1, 32'h0);
    @(posedge clock);
    normal <= 1'b1;
    repeat (4) @(posedge clock);
    c = wr_cnt;
    xf(8'h40, 8'hA0, Z, 16'h0100, 16'h0004, 32'h0, 1'b1, 32'h0);
    xf(8'hC0, 8'hA1, Z, 16'h0200, 16'h0004, 32'h0, 1'b1, 32'h0);
    xf(8'hC0, 8'hA1, Z, 16'h00B8, 16'h0004, 32'h0, 1'b0, 32'hA5C3_00B8);
    chk(32'(wr_cnt - c), 32'h0);
  endtask
  initial begin
    rst_n = 1'b0;
    self_pwr = 1'b1;
    normal = 1'b0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 8'h0;
    sw_wdata = 32'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_std();
    t_cfg();
    t_vnd();
    final_report();
  end
endmodule
